// >>> rtl/sdram_cfg.svh
// Offsets, field positions, reset values and counts of the column logic
`ifndef SDRAM_CFG_SVH
`define SDRAM_CFG_SVH

// Bank address that selects the mode register or extended mode register 1
`define MR_SEL          3'h0
`define EMR1_SEL        3'h1

// Mode register fields
`define MR_BL_LSB       0
`define MR_BT_BIT       3
`define MR_CL_LSB       4
`define BL_CODE4        3'h2
`define BL_CODE8        3'h3

// Extended mode register 1 fields
`define EMR_AL_LSB      3
`define EMR_DQS_DIS_BIT 10
`define AL_MAX          3'h4

// Precharge all banks select bit
`define PRE_ALL_BIT     10

// Reset values
`define RST_BL8         1'b0
`define RST_BT          1'b0
`define RST_CL          3'h3
`define RST_AL          3'h0
`define RST_DQS_DIFF    1'b1

// Stored column bits per bank and write abort slack in clocks
`define COL_STORE_BITS  4
`define WR_SLACK        5'h02

`endif

// >>> rtl/sdram_pkg.sv
// Types shared by the column access and precharge logic
package sdram_pkg;

    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_MRS,
        CMD_ACT,
        CMD_READ,
        CMD_WRITE,
        CMD_PRE
    } cmd_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_RD_PRE,
        ST_RD_DATA,
        ST_WR_WAIT,
        ST_WR_DATA
    } burst_state_e;

    typedef logic [6:0] mem_idx_t;

endpackage : sdram_pkg

// >>> rtl/burst_order.sv
// Column order of one beat inside a burst
`timescale 1ns/100ps
`default_nettype none

module burst_order (
    input  wire logic       [2:0] start_col,
    input  wire logic       [2:0] beat,
    input  wire logic             bl8,
    input  wire logic             interleave,
    output logic            [2:0] col
);

    logic [1:0] seq_low;

    assign seq_low = start_col[1:0] + beat[1:0];

    always_comb begin
        if (interleave) begin
            col = bl8 ? (start_col ^ beat)
                      : {start_col[2], start_col[1:0] ^ beat[1:0]};
        end else begin
            // Nibble wrap; an 8 burst flips to the other half after 4 beats
            col = {bl8 ? (start_col[2] ^ beat[2]) : start_col[2], seq_low};
        end
    end

endmodule : burst_order

`default_nettype wire

// >>> rtl/beat_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module beat_buffer #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] slot [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = slot[rd_ptr];

    always_ff @(posedge mclk) begin
        if (push) begin
            slot[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule : beat_buffer

`default_nettype wire

// >>> rtl/sdram_burst_precharge.sv
// Column access, burst ordering, strobes, data mask and precharge of a DDR2
`timescale 1ns/100ps
`default_nettype none
`include "sdram_cfg.svh"

module sdram_burst_precharge (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ck,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [2:0]  ba,
    input  wire logic [12:0] addr,
    input  wire logic [1:0]  dm,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic             dq_oe_n,
    input  wire logic        dqs_in,
    output logic             dqs_out,
    output logic             dqs_oe_n,
    output logic             dqs_b_out,
    output logic             dqs_b_oe_n,
    input  wire logic        array_hold,
    output logic      [7:0]  bank_open,
    output logic             burst_len8,
    output logic             interleaved,
    output logic      [2:0]  cas_latency,
    output logic      [2:0]  add_latency,
    output logic             dqs_diff,
    output logic             rd_busy,
    output logic             wr_busy,
    output logic             wr_dropped
);

    localparam int SW = 40;
    localparam logic [SW-1:0] SYNC_RST = {4'hF, 36'h0};
    localparam int BW = 7 + 16 + 2;

    // Three-stage pin synchroniser, all pins share one latency
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] sync3;
    logic [SW-1:0] pin_q;

    assign pin_raw = {cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq_in,
                      dqs_in, ck};

    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1[gi] <= SYNC_RST[gi];
                    sync2[gi] <= SYNC_RST[gi];
                    sync3[gi] <= SYNC_RST[gi];
                    pin_q[gi] <= SYNC_RST[gi];
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        pin_q[gi] <= sync2[gi];
                    end
                end
            end
        end
    endgenerate

    logic        ck_q;
    logic        dqs_q;
    logic [15:0] dq_q;
    logic [1:0]  dm_q;
    logic [12:0] a_q;
    logic [2:0]  ba_q;
    logic        ck_prev;
    logic        dqs_prev;
    logic        ck_rise;
    logic        ck_fall;
    logic        dqs_edge;

    assign ck_q  = pin_q[0];
    assign dqs_q = pin_q[1];
    assign dq_q  = pin_q[17:2];
    assign dm_q  = pin_q[19:18];
    assign a_q   = pin_q[32:20];
    assign ba_q  = pin_q[35:33];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ck_prev  <= 1'b0;
            dqs_prev <= 1'b0;
        end else begin
            ck_prev  <= ck_q;
            dqs_prev <= dqs_q;
        end
    end

    assign ck_rise  = ck_q & ~ck_prev;
    assign ck_fall  = ~ck_q & ck_prev;
    assign dqs_edge = dqs_q ^ dqs_prev;

    // Command decode at the rising edge of the link clock
    function automatic sdram_pkg::cmd_e decode(input logic [3:0] c);
        sdram_pkg::cmd_e r;
        r = sdram_pkg::CMD_NOP;
        if (!c[3]) begin
            case (c[2:0])
                3'h0:    r = sdram_pkg::CMD_MRS;
                3'h3:    r = sdram_pkg::CMD_ACT;
                3'h5:    r = sdram_pkg::CMD_READ;
                3'h4:    r = sdram_pkg::CMD_WRITE;
                3'h2:    r = sdram_pkg::CMD_PRE;
                // Burst stop pattern falls to no operation
                default: r = sdram_pkg::CMD_NOP;
            endcase
        end
        return r;
    endfunction : decode

    sdram_pkg::cmd_e cmd;

    assign cmd = ck_rise ? decode(pin_q[39:36]) : sdram_pkg::CMD_NOP;

    // Mode and extended mode registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            burst_len8  <= `RST_BL8;
            interleaved <= `RST_BT;
            cas_latency <= `RST_CL;
            add_latency <= `RST_AL;
            dqs_diff    <= `RST_DQS_DIFF;
        end else if (cmd == sdram_pkg::CMD_MRS) begin
            if (ba_q == `MR_SEL) begin
                // Other length codes keep the previous length
                if (a_q[`MR_BL_LSB +: 3] == `BL_CODE4) begin
                    burst_len8 <= 1'b0;
                end else if (a_q[`MR_BL_LSB +: 3] == `BL_CODE8) begin
                    burst_len8 <= 1'b1;
                end
                interleaved <= a_q[`MR_BT_BIT];
                cas_latency <= a_q[`MR_CL_LSB +: 3];
            end else if (ba_q == `EMR1_SEL) begin
                if (a_q[`EMR_AL_LSB +: 3] <= `AL_MAX) begin
                    add_latency <= a_q[`EMR_AL_LSB +: 3];
                end
                dqs_diff <= ~a_q[`EMR_DQS_DIS_BIT];
            end
        end
    end

    // Open bank tracking
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bank_open <= 8'h00;
        end else if (cmd == sdram_pkg::CMD_ACT) begin
            bank_open[ba_q] <= 1'b1;
        end else if (cmd == sdram_pkg::CMD_PRE) begin
            if (a_q[`PRE_ALL_BIT]) begin
                bank_open <= 8'h00;
            end else begin
                bank_open[ba_q] <= 1'b0;
            end
        end
    end

    // Burst engine
    sdram_pkg::burst_state_e state;
    logic [4:0] clk_cnt;
    logic [4:0] next_cnt;
    logic [4:0] rd_lat;
    logic [4:0] wr_lat;
    logic [4:0] half_bl;
    logic [3:0] beat;
    logic [3:0] last_beat;
    logic [2:0] bank;
    logic [3:0] start_col;
    logic [2:0] col;
    logic       wr_take;
    sdram_pkg::mem_idx_t idx;

    assign rd_lat    = 5'({2'h0, add_latency}) + 5'({2'h0, cas_latency});
    assign wr_lat    = rd_lat - 5'h01;
    assign half_bl   = burst_len8 ? 5'h04 : 5'h02;
    assign last_beat = burst_len8 ? 4'h7 : 4'h3;
    assign next_cnt  = clk_cnt + 5'h01;
    assign rd_busy   = (state == sdram_pkg::ST_RD_WAIT) ||
                       (state == sdram_pkg::ST_RD_PRE) ||
                       (state == sdram_pkg::ST_RD_DATA);
    assign wr_busy   = (state == sdram_pkg::ST_WR_WAIT) ||
                       (state == sdram_pkg::ST_WR_DATA);
    // First captured edge must be rising; falling edges only follow it
    assign wr_take   = (state == sdram_pkg::ST_WR_DATA) && dqs_edge &&
                       (beat != 4'h0 || dqs_q);

    burst_order u_order (
        .start_col  (start_col[2:0]),
        .beat       (beat[2:0]),
        .bl8        (burst_len8),
        .interleave (interleaved),
        .col        (col)
    );

    assign idx = {bank, start_col[3], col};

    logic [15:0] mem [128];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= sdram_pkg::ST_IDLE;
            clk_cnt   <= 5'h00;
            beat      <= 4'h0;
            bank      <= 3'h0;
            start_col <= 4'h0;
        end else begin
            case (state)
                sdram_pkg::ST_IDLE: begin
                    clk_cnt <= 5'h00;
                    beat    <= 4'h0;
                    bank    <= ba_q;
                    start_col <= a_q[`COL_STORE_BITS-1:0];
                    if (cmd == sdram_pkg::CMD_READ) begin
                        state <= sdram_pkg::ST_RD_WAIT;
                    end else if (cmd == sdram_pkg::CMD_WRITE) begin
                        state <= (wr_lat == 5'h01) ? sdram_pkg::ST_WR_DATA
                                                  : sdram_pkg::ST_WR_WAIT;
                    end
                end
                sdram_pkg::ST_RD_WAIT: begin
                    if (ck_rise) begin
                        clk_cnt <= next_cnt;
                        if (next_cnt == rd_lat - 5'h01) begin
                            state <= sdram_pkg::ST_RD_PRE;
                        end
                    end
                end
                sdram_pkg::ST_RD_PRE: begin
                    if (ck_rise) begin
                        beat  <= 4'h1;
                        state <= sdram_pkg::ST_RD_DATA;
                    end
                end
                sdram_pkg::ST_RD_DATA: begin
                    if (ck_rise || ck_fall) begin
                        beat <= beat + 4'h1;
                        if (beat == last_beat + 4'h1) begin
                            state <= sdram_pkg::ST_IDLE;
                        end
                    end
                end
                sdram_pkg::ST_WR_WAIT: begin
                    if (ck_rise) begin
                        clk_cnt <= next_cnt;
                        if (next_cnt == wr_lat - 5'h01) begin
                            state <= sdram_pkg::ST_WR_DATA;
                        end
                    end
                end
                sdram_pkg::ST_WR_DATA: begin
                    if (ck_rise) begin
                        clk_cnt <= next_cnt;
                    end
                    if (wr_take) begin
                        beat <= beat + 4'h1;
                        if (beat == last_beat) begin
                            state <= sdram_pkg::ST_IDLE;
                        end
                    end else if (ck_rise &&
                                 next_cnt == wr_lat + half_bl + `WR_SLACK) begin
                        // Missing strobes: give the burst up
                        state <= sdram_pkg::ST_IDLE;
                    end
                end
                default: state <= sdram_pkg::ST_IDLE;
            endcase
        end
    end

    // Read data and strobe drive
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out    <= 16'h0000;
            dq_oe_n   <= 1'b1;
            dqs_out   <= 1'b0;
            dqs_b_out <= 1'b1;
            dqs_oe_n  <= 1'b1;
        end else if (state == sdram_pkg::ST_RD_WAIT && ck_rise &&
                     next_cnt == rd_lat - 5'h01) begin
            dqs_out   <= 1'b0;
            dqs_b_out <= 1'b1;
            dqs_oe_n  <= 1'b0;
        end else if (state == sdram_pkg::ST_RD_PRE && ck_rise) begin
            dq_out    <= mem[idx];
            dq_oe_n   <= 1'b0;
            dqs_out   <= 1'b1;
            dqs_b_out <= 1'b0;
        end else if (state == sdram_pkg::ST_RD_DATA && (ck_rise || ck_fall))
        begin
            if (beat == last_beat + 4'h1) begin
                dq_oe_n  <= 1'b1;
                dqs_oe_n <= 1'b1;
                dqs_out  <= 1'b0;
            end else begin
                dq_out    <= mem[idx];
                dqs_out   <= ck_rise;
                dqs_b_out <= ~ck_rise;
            end
        end
    end

    assign dqs_b_oe_n = dqs_oe_n | ~dqs_diff;

    // Write beats pass a two-entry buffer before the array
    logic [BW-1:0] buf_out;
    logic          buf_in_ready;
    logic          buf_out_valid;
    logic          buf_pop;
    logic [15:0]   keep;

    beat_buffer #(
        .WIDTH (BW),
        .DEPTH (2)
    ) u_buffer (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (wr_take),
        .in_ready  (buf_in_ready),
        .in_data   ({idx, dq_q, dm_q}),
        .out_valid (buf_out_valid),
        .out_ready (~array_hold),
        .out_data  (buf_out)
    );

    assign buf_pop = buf_out_valid & ~array_hold;
    assign keep    = {{8{buf_out[1]}}, {8{buf_out[0]}}};

    always_ff @(posedge mclk) begin
        if (buf_pop) begin
            mem[buf_out[BW-1 -: 7]] <= (mem[buf_out[BW-1 -: 7]] & keep) |
                                       (buf_out[17:2] & ~keep);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_dropped <= 1'b0;
        end else if (wr_take && !buf_in_ready) begin
            wr_dropped <= 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_pre_all: assert property (
        cmd == sdram_pkg::CMD_PRE && a_q[`PRE_ALL_BIT] |=> bank_open == 8'h00)
        else $error("precharge all left a bank open");

    chk_pre_one: assert property (
        cmd == sdram_pkg::CMD_PRE && !a_q[`PRE_ALL_BIT] |=>
        !bank_open[$past(ba_q)] &&
        ((bank_open | (8'h01 << $past(ba_q))) ==
         ($past(bank_open) | (8'h01 << $past(ba_q)))))
        else $error("single precharge touched wrong banks");

    chk_bl_load: assert property (
        cmd == sdram_pkg::CMD_MRS && ba_q == `MR_SEL &&
        a_q[2:0] == `BL_CODE8 |=> burst_len8)
        else $error("burst length eight not loaded");

    chk_bt_load: assert property (
        cmd == sdram_pkg::CMD_MRS && ba_q == `MR_SEL |=>
        interleaved == $past(a_q[`MR_BT_BIT]))
        else $error("burst type not loaded");

    chk_seq_order: assert property (
        !interleaved |-> col[1:0] == 2'(start_col[1:0] + beat[1:0]))
        else $error("sequential order wrong");

    chk_int_order: assert property (
        interleaved && burst_len8 |-> col == (start_col[2:0] ^ beat[2:0]))
        else $error("interleaved order wrong");

    chk_read_pre: assert property (
        $fell(dqs_oe_n) |-> !dqs_out && dq_oe_n
        ##1 (!dqs_out && dq_oe_n)[*3])
        else $error("read preamble missing");

    chk_read_lat: assert property (
        $fell(dqs_oe_n) |-> clk_cnt == rd_lat - 5'h01)
        else $error("read latency wrong");

    chk_wr_limit: assert property (
        wr_take |-> beat <= last_beat)
        else $error("too many write beats taken");

    chk_dqs_single: assert property (
        !dqs_diff |-> dqs_b_oe_n)
        else $error("complement strobe driven in single mode");

    chk_al_range: assert property (
        add_latency <= `AL_MAX)
        else $error("additive latency out of range");

    cov_read8: cover property (
        state == sdram_pkg::ST_RD_DATA && burst_len8 && beat == 4'h8);
    cov_write_masked: cover property (buf_pop && buf_out[1:0] != 2'h0);
    cov_stall: cover property (wr_take && !buf_in_ready);
    cov_pre_all: cover property (
        cmd == sdram_pkg::CMD_PRE && a_q[`PRE_ALL_BIT]);

endmodule : sdram_burst_precharge

`default_nettype wire

// >>> test/ddr_ctl_model.sv
// Controller model driving commands, strobe and write data
`timescale 1ns/100ps
`default_nettype none

module ddr_ctl_model (
    input  wire logic        mclk,
    output logic             ck,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic      [2:0]  ba,
    output logic      [12:0] addr,
    output logic      [1:0]  dm,
    output logic      [15:0] dq_in,
    output logic             dqs_in
);
    initial begin
        {ck, dqs_in, dm, dq_in, ba, addr} = '0;
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        #3.3;
        forever #80 ck = ~ck;
    end

    // Pins change after a ck fall and hold six mclk past the next rise
    task automatic cmd(input logic [2:0] rcw, input logic [2:0] b,
                       input logic [12:0] a);
        @(negedge ck);
        @(posedge mclk);
        {cs_n, ras_n, cas_n, we_n} <= {1'b0, rcw};
        ba <= b;
        addr <= a;
        @(posedge ck);
        repeat (6) @(posedge mclk);
        cs_n <= 1'b1;
    endtask : cmd

    // Whole burst plus one extra beat; data centred on each strobe edge
    task automatic wr(input int wl, input int n, input logic [127:0] d,
                      input logic [15:0] m);
        repeat (wl - 1) @(posedge ck);
        dqs_in <= 1'b0;
        @(posedge ck);
        for (int i = 0; i <= n; i++) begin
            @(posedge mclk);
            dq_in <= d[16*(i%8) +: 16];
            dm <= m[2*(i%8) +: 2];
            repeat (8) @(posedge mclk);
            dqs_in <= ~dqs_in;
            repeat (7) @(posedge mclk);
        end
        dqs_in <= 1'b0;
        dq_in <= ~dq_in;
    endtask : wr
endmodule : ddr_ctl_model
`default_nettype wire

// >>> test/sdram_burst_precharge_tb.sv
// Self-checking bench of the column access and precharge logic
`timescale 1ns/100ps
`default_nettype none

module sdram_burst_precharge_tb;
    logic        mclk, rst_n, ck, cs_n, ras_n, cas_n, we_n, dqs_in;
    logic        dq_oe_n, dqs_out, dqs_oe_n, dqs_b_oe_n, array_hold;
    logic        burst_len8, interleaved, dqs_diff, rd_busy, wr_busy;
    logic        wr_dropped, dqs_b_out;
    logic [2:0]  ba, cas_latency, add_latency;
    logic [12:0] addr;
    logic [1:0]  dm;
    logic [15:0] dq_in, dq_out;
    logic [7:0]  bank_open;
    logic [15:0] mem [8];
    int          n_fail, checked, cyc;

    sdram_burst_precharge u_dut (.mclk, .rst_n, .ck, .cs_n, .ras_n,
        .cas_n, .we_n, .ba, .addr, .dm, .dq_in, .dq_out, .dq_oe_n,
        .dqs_in, .dqs_out, .dqs_oe_n, .dqs_b_out, .dqs_b_oe_n,
        .array_hold, .bank_open, .burst_len8, .interleaved, .cas_latency,
        .add_latency, .dqs_diff, .rd_busy, .wr_busy, .wr_dropped);
    ddr_ctl_model u_ctl (.mclk, .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba,
        .addr, .dm, .dq_in, .dqs_in);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic close_out;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [2:0] ord(logic [2:0] s, logic [2:0] i,
                                       logic il);
        return il ? s ^ i : {s[2] ^ i[2], s[1:0] + i[1:0]};
    endfunction : ord

    task automatic cmd_wait(input logic [2:0] rcw, input logic [2:0] b,
                            input logic [12:0] a);
        u_ctl.cmd(rcw, b, a);
        repeat (12) @(posedge mclk);
    endtask : cmd_wait

    task automatic rd(input logic [2:0] s, input logic il,
                      input logic b8, input int rl, input logic se);
        int n;
        n = 0;
        u_ctl.cmd(3'h5, 3'h2, {10'h000, s});
        while (dqs_oe_n !== 1'b0 && n < 12) begin
            @(posedge ck);
            n++;
        end
        chk(16'(n), 16'(rl));
        chk(16'({dq_oe_n, dqs_out}), 16'h0002);
        chk(16'({dqs_b_oe_n, dqs_b_out}), 16'({se, 1'b1}));
        repeat (9) @(posedge mclk);
        for (int i = 0; i < (b8 ? 8 : 4); i++) begin
            chk(dq_out, mem[ord(s, 3'(i), il)]);
            chk(16'({dqs_out, dqs_b_out}), 16'({!i[0], i[0]}));
            repeat (16) @(posedge mclk);
        end
        repeat (2) @(posedge ck);
    endtask : rd

    initial begin
        logic [127:0] d;
        logic [15:0]  m;
        logic [2:0]   al, cl;
        int           bl;
        rst_n = 1'b0;
        array_hold = 1'b0;
        {cyc, n_fail, checked} = '0;
        void'($urandom(32'h57E0D9ED));
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk(16'({burst_len8, add_latency, cas_latency, dqs_diff}),
            16'h0007);
        for (int k = 0; k < 2; k++) begin
            al = k ? 3'h2 : 3'h0;
            cl = k ? 3'h4 : 3'h3;
            bl = k ? 4 : 8;
            cmd_wait(3'h0, 3'h0, {6'h00, cl, 1'b0, 2'h1, 1'(k == 0)});
            cmd_wait(3'h0, 3'h1, {2'h0, 1'(k), 4'h0, al, 3'h0});
            chk(16'({burst_len8, add_latency, cas_latency, dqs_diff}),
                16'({1'(k == 0), al, cl, 1'(k == 0)}));
            cmd_wait(3'h3, 3'h2, 13'h0000);
            for (int i = 0; i < 8; i++) d[16*i +: 16] = 16'($urandom);
            m = k ? 16'h0004 : 16'h0000;
            u_ctl.cmd(3'h4, 3'h2, 13'h0000);
            u_ctl.wr(al + cl - 1, bl, d, m);
            for (int i = 0; i < bl; i++) begin
                if (!m[2*i]) mem[i][7:0] = d[16*i +: 8];
                if (!m[2*i+1]) mem[i][15:8] = d[16*i+8 +: 8];
            end
            repeat (3) @(posedge ck);
            for (int il = 0; il < 2; il++) begin
                cmd_wait(3'h0, 3'h0, {6'h00, cl, 1'(il), 2'h1,
                         1'(k == 0)});
                chk(16'(interleaved), 16'(il));
                rd(3'($urandom), 1'(il), 1'(k == 0), al + cl, 1'(k));
            end
            $display("config %0d done", k);
        end
        // Banks idle long after the last burst before any precharge
        cmd_wait(3'h3, 3'h5, 13'h0000);
        chk(16'(bank_open), 16'h0024);
        cmd_wait(3'h6, 3'h5, 13'h0000);
        chk(16'(bank_open), 16'h0024);
        cmd_wait(3'h2, 3'h2, 13'h0000);
        chk(16'(bank_open), 16'h0020);
        cmd_wait(3'h3, 3'h2, 13'h0000);
        cmd_wait(3'h2, 3'h2, 13'h0400);
        chk(16'(bank_open), 16'h0000);
        $display("precharge done");
        array_hold <= 1'b1;
        cmd_wait(3'h3, 3'h2, 13'h0000);
        chk(16'(wr_dropped), 16'h0000);
        u_ctl.cmd(3'h4, 3'h2, 13'h0000);
        u_ctl.wr(5, 4, d, 16'h0000);
        chk(16'(wr_dropped), 16'h0001);
        array_hold <= 1'b0;
        repeat (3) @(posedge ck);
        chk(16'({rd_busy, wr_busy}), 16'h0000);
        $display("overflow done");
        close_out();
    end
endmodule : sdram_burst_precharge_tb
`default_nettype wire
